// >>> src/rwg_pkg.sv
// package: register write guard constants and bus carrier types
package rwg_pkg;
    localparam int          RWG_NREGS        = 8;
    localparam int          RWG_IDX_W        = 3;
    // guarded peripheral registers at word offsets 0x000..0x01c
    localparam logic [11:0] RWG_PERIPH_BASE  = 12'h000;
    // soft lock set bits, one word per guarded register
    localparam logic [11:0] RWG_SOFT_BASE    = 12'h800;
    // global configuration register
    localparam logic [11:0] RWG_GCR_ADDR     = 12'hf00;
    // lock status register (read only)
    localparam logic [11:0] RWG_STAT_ADDR    = 12'hf04;
    localparam int          RWG_GCR_PERM_BIT = 0;
    localparam int          RWG_GCR_SUP_BIT  = 1;
    localparam logic [31:0] RWG_DATA_RST     = 32'h0000_0000;
    localparam logic [1:0]  RWG_GCR_RST      = 2'h0;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic        supervisor;
    } rwg_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rwg_apb_rsp_t;

    typedef enum logic [1:0] {
        RWG_IDLE   = 2'b01,
        RWG_ACCESS = 2'b10
    } rwg_state_t;
endpackage

// >>> src/rwg_guard.sv
// register write guard: guarded register bank with soft, permanent and privilege locks
// Notes on behaviour
// - each guarded register location is protected on its own
// - a set soft lock rejects every write to its register
// - a soft lock clears by software writing zero or by reset
// - the permanent lock rejects writes to all guarded registers
// - permanent lock ignores software clears; only reset releases it
// - with no lock, supervisor-only mode rejects user writes
// - each guarded register owns a soft lock bit in guard space
// - config register holds permanent lock bit; writing 1 engages it
// - guard control locations are reachable by ordinary bus accesses
`timescale 1ns/1ps
module rwg_guard (
    // clock, reset, enable
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // apb slave
    input  wire rwg_pkg::rwg_apb_req_t apb_req,
    output rwg_pkg::rwg_apb_rsp_t      apb_rsp,
    // lock state
    output logic                       perm_lock,
    output logic                       write_rejected
);
    import rwg_pkg::*;

    logic [31:0]          data_q [RWG_NREGS];
    logic [RWG_NREGS-1:0] soft_q;
    logic                 perm_q;
    logic                 sup_only_q;
    rwg_state_t           state_q;
    rwg_apb_rsp_t         rsp_q;
    logic                 rej_q;

    function automatic logic in_range(input logic [11:0] a, input logic [11:0] base);
        in_range = (a[11:5] == base[11:5]) && (a[1:0] == 2'h0);
    endfunction

    logic                 acc;
    logic                 wr;
    logic [RWG_IDX_W-1:0] idx;
    logic                 hit_data;
    logic                 hit_soft;
    logic                 hit_gcr;
    logic                 hit_stat;
    logic                 blocked;

    assign acc      = apb_req.psel && apb_req.penable && state_q == RWG_ACCESS;
    assign wr       = acc && apb_req.pwrite;
    assign idx      = apb_req.paddr[4:2];
    assign hit_data = in_range(apb_req.paddr, RWG_PERIPH_BASE);
    assign hit_soft = in_range(apb_req.paddr, RWG_SOFT_BASE);
    assign hit_gcr  = apb_req.paddr == RWG_GCR_ADDR;
    assign hit_stat = apb_req.paddr == RWG_STAT_ADDR;
    // priority: soft lock, permanent lock, then privilege
    assign blocked  = soft_q[idx] || perm_q || (sup_only_q && !apb_req.supervisor);

    // setup then one access cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= RWG_IDLE;
        end else if (ce) begin
            case (state_q)
                RWG_IDLE: begin
                    if (apb_req.psel && !apb_req.penable) begin
                        state_q <= RWG_ACCESS;
                    end
                end
                RWG_ACCESS: state_q <= RWG_IDLE;
                default:    state_q <= RWG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < RWG_NREGS; i++) begin
                data_q[i] <= RWG_DATA_RST;
            end
        end else if (ce && wr && hit_data && !blocked) begin
            data_q[idx] <= apb_req.pwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            soft_q <= '0;
        end else if (ce && wr && hit_soft) begin
            soft_q[idx] <= apb_req.pwdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            perm_q     <= RWG_GCR_RST[RWG_GCR_PERM_BIT];
            sup_only_q <= RWG_GCR_RST[RWG_GCR_SUP_BIT];
        end else if (ce && wr && hit_gcr) begin
            perm_q <= perm_q | apb_req.pwdata[RWG_GCR_PERM_BIT];
            if (!perm_q) begin
                sup_only_q <= apb_req.pwdata[RWG_GCR_SUP_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_q <= '0;
            rej_q <= 1'b0;
        end else if (ce) begin
            rsp_q.pready  <= apb_req.psel && !apb_req.penable && state_q == RWG_IDLE;
            rsp_q.pslverr <= 1'b0;
            rsp_q.prdata  <= 32'h0000_0000;
            rej_q         <= 1'b0;
            if (apb_req.psel && !apb_req.penable && state_q == RWG_IDLE) begin
                rsp_q.pslverr <= !(in_range(apb_req.paddr, RWG_PERIPH_BASE)
                                 || in_range(apb_req.paddr, RWG_SOFT_BASE)
                                 || apb_req.paddr == RWG_GCR_ADDR
                                 || apb_req.paddr == RWG_STAT_ADDR);
                if (in_range(apb_req.paddr, RWG_PERIPH_BASE)) begin
                    rsp_q.prdata <= data_q[apb_req.paddr[4:2]];
                end else if (in_range(apb_req.paddr, RWG_SOFT_BASE)) begin
                    rsp_q.prdata <= {31'h0, soft_q[apb_req.paddr[4:2]]};
                end else if (apb_req.paddr == RWG_GCR_ADDR) begin
                    rsp_q.prdata <= {30'h0, sup_only_q, perm_q};
                end else if (apb_req.paddr == RWG_STAT_ADDR) begin
                    rsp_q.prdata <= {24'h0, soft_q};
                end
            end
            if (wr && hit_data && blocked) begin
                rej_q <= 1'b1;
            end
        end
    end

    assign apb_rsp        = rsp_q;
    assign perm_lock      = perm_q;
    assign write_rejected = rej_q;

    property p_perm_sticky;
        @(posedge clock) disable iff (rst) perm_q |=> perm_q;
    endproperty
    a_perm_sticky: assert property (p_perm_sticky) else $error("perm lock cleared");

    property p_perm_set;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_gcr && apb_req.pwdata[RWG_GCR_PERM_BIT]) |=> perm_q;
    endproperty
    a_perm_set: assert property (p_perm_set) else $error("perm lock not set");

    property p_soft_block;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_data && soft_q[idx])
                |=> data_q[$past(idx)] == $past(data_q[idx]);
    endproperty
    a_soft_block: assert property (p_soft_block) else $error("soft locked write taken");

    property p_perm_block;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_data && perm_q)
                |=> data_q[$past(idx)] == $past(data_q[idx]) && rej_q;
    endproperty
    a_perm_block: assert property (p_perm_block) else $error("perm locked write taken");

    property p_user_block;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_data && sup_only_q && !apb_req.supervisor) |=> rej_q;
    endproperty
    a_user_block: assert property (p_user_block) else $error("user write not rejected");

    property p_write_lands;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_data && !blocked) |=> data_q[$past(idx)] == $past(apb_req.pwdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");

    property p_soft_clear;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_soft && !apb_req.pwdata[0]) |=> !soft_q[$past(idx)];
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft lock not cleared");

    property p_ready;
        @(posedge clock) disable iff (rst)
            (ce && apb_req.psel && !apb_req.penable && state_q == RWG_IDLE) |=> rsp_q.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no pready");

    property p_ce_freeze;
        @(posedge clock) disable iff (rst)
            (!ce && !rst) |=> $stable(perm_q) && $stable(soft_q) && $stable(rsp_q);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low");

    property p_no_false_reject;
        @(posedge clock) disable iff (rst)
            (ce && wr && hit_data && !blocked) |=> !rej_q;
    endproperty
    a_no_false_reject: assert property (p_no_false_reject) else $error("clean write flagged");

    property p_stat_read;
        @(posedge clock) disable iff (rst)
            (ce && apb_req.psel && !apb_req.penable && state_q == RWG_IDLE && hit_stat)
                |=> rsp_q.prdata == {24'h0, $past(soft_q)};
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");
endmodule

// >>> testbench/rwg_master.sv
// apb master model standing in for a processor core
`timescale 1ns/1ps
module rwg_master (
    // clock
    input  wire logic                  clock,
    // apb master side
    output rwg_pkg::rwg_apb_req_t      req,
    input  wire rwg_pkg::rwg_apb_rsp_t rsp
);
    import rwg_pkg::*;
    initial req = '0;
    // one transfer, entered just after a rising edge; a hang is left to the watchdog
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic s, output logic [31:0] rd, output logic e);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, supervisor: s};
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        e  = rsp.pslverr;
    endtask
    // released lines show inverted values
    task automatic idle();
        req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~req.pwrite, paddr: ~req.paddr,
                 pwdata: ~req.pwdata, supervisor: ~req.supervisor};
    endtask
endmodule

// >>> testbench/rwg_guard_tb_top.sv
// self-checking bench for the register write guard
`timescale 1ns/1ps
module rwg_guard_tb_top;
    import rwg_pkg::*;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic        s;
        logic [31:0] rd;
        logic        e;
        logic        rj;
        logic        pl;
    } rwg_row_t;
    logic         clock = 1'b0;
    logic         rst   = 1'b1;
    logic         ce    = 1'b1;
    rwg_apb_req_t req;
    rwg_apb_rsp_t rsp;
    logic         perm_lock;
    logic         write_rejected;
    int           errors    = 0;
    int           tests_run = 0;
    rwg_row_t     rows [20];
    always #10 clock = ~clock;
    rwg_guard rwg_guard_i (.clock(clock), .rst(rst), .ce(ce), .apb_req(req),
        .apb_rsp(rsp), .perm_lock(perm_lock), .write_rejected(write_rejected));
    rwg_master rwg_master_i (.clock(clock), .req(req), .rsp(rsp));
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic acc(input rwg_row_t r);
        logic [31:0] rd;
        logic        e;
        rwg_master_i.xfer(r.w, r.a, r.d, r.s, rd, e);
        rwg_master_i.idle();
        @(posedge clock);
        chk("pslverr", {31'h0, r.e}, {31'h0, e});
        chk("write_rejected", {31'h0, r.rj}, {31'h0, write_rejected});
        chk("perm_lock", {31'h0, r.pl}, {31'h0, perm_lock});
        if (!r.w) chk("prdata", r.rd, rd);
    endtask
    task automatic stop_test();
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clock);
        errors++;
        stop_test();
    end
    initial begin
        rows = '{
            '{1, 'h000, 'h1111_1111, 1, 0, 0, 0, 0},
            '{0, 'h000, 0, 1, 'h1111_1111, 0, 0, 0},
            '{1, 'h804, 1, 1, 0, 0, 0, 0},
            '{1, 'h004, 'h22, 1, 0, 0, 1, 0},
            '{0, 'h004, 0, 1, 0, 0, 0, 0},
            '{0, 'hf04, 0, 1, 'h2, 0, 0, 0},
            '{1, 'h804, 0, 1, 0, 0, 0, 0},
            '{1, 'h004, 'h22, 1, 0, 0, 0, 0},
            '{0, 'h004, 0, 1, 'h22, 0, 0, 0},
            '{1, 'hf00, 'h2, 1, 0, 0, 0, 0},
            '{1, 'h008, 'h33, 0, 0, 0, 1, 0},
            '{1, 'h008, 'h33, 1, 0, 0, 0, 0},
            '{0, 'h008, 0, 1, 'h33, 0, 0, 0},
            '{0, 'h400, 0, 1, 0, 1, 0, 0},
            '{1, 'h800, 1, 1, 0, 0, 0, 0},
            '{1, 'hf00, 'h3, 1, 0, 0, 0, 1},
            '{1, 'h00c, 'h44, 1, 0, 0, 1, 1},
            '{1, 'hf00, 0, 1, 0, 0, 0, 1},
            '{0, 'hf00, 0, 1, 'h3, 0, 0, 1},
            '{0, 'h00c, 0, 1, 0, 0, 0, 1}
        };
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        foreach (rows[i]) acc(rows[i]);
        // clock enable low holds every lock
        ce <= 1'b0;
        repeat (3) @(posedge clock);
        ce <= 1'b1;
        @(posedge clock);
        chk("perm_lock", 32'h1, {31'h0, perm_lock});
        acc('{0, 'hf00, 0, 1, 'h3, 0, 0, 1});
        // mid-run reset drops every lock and clears data
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("perm_lock", 32'h0, {31'h0, perm_lock});
        acc('{0, 'hf04, 0, 1, 0, 0, 0, 0});
        acc('{0, 'h000, 0, 1, 0, 0, 0, 0});
        acc('{1, 'h00c, 'h55, 0, 0, 0, 0, 0});
        acc('{0, 'h00c, 0, 0, 'h55, 0, 0, 0});
        stop_test();
    end
endmodule
